/* File: hdl/spmask_pkg.sv */
// Constants and carrier types for the stack select and priority floor block
package spmask_pkg;
  localparam int SREG_SEL_W       = 2;
  localparam logic [1:0] SREG_PRIO_FLOOR = 2'h1;
  localparam logic [1:0] SREG_THREAD_CTL = 2'h2;
  localparam int FLOOR_LSB        = 5;
  localparam int FLOOR_W          = 3;
  localparam int ASEL_BIT         = 1;
  localparam int TPRIV_BIT        = 0;
  localparam logic [2:0] FLOOR_RST = 3'h0;
  localparam logic       ASEL_RST  = 1'b0;
  localparam logic       TPRIV_RST = 1'b0;
  localparam int ERC_SPSEL_BIT    = 2;
  localparam int ERC_THREAD_BIT   = 3;
  localparam int ERC_W            = 4;

  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [SREG_SEL_W-1:0] sel;
    logic [31:0]           wdata;
    logic                  privileged;
    logic                  handler;
  } sreg_req_t;

  typedef struct packed {
    logic       entry;
    logic       ret;
    logic [ERC_W-1:0] code;
  } exc_evt_t;

  typedef struct packed {
    logic [FLOOR_W-1:0] floor;
    logic               asel;
    logic               tpriv;
    logic [31:0]        rdata;
    logic               rvalid;
    logic               use_psp;
    logic               unpriv;
  } ctl_state_t;
endpackage

/* File: hdl/prio_floor_cmp.sv */
// Priority floor comparison against a candidate exception level
`timescale 1ns/1ps
module prio_floor_cmp (
  input  wire logic [spmask_pkg::FLOOR_W-1:0] floor,
  input  wire logic [spmask_pkg::FLOOR_W-1:0] level,
  output logic                                blocked
);
  import spmask_pkg::*;
  // Level 0 is highest; floor 0 disables masking
  assign blocked = (floor != FLOOR_RST) && (level >= floor);
endmodule

/* File: hdl/stack_and_priority_mask_ctrl.sv */
// Thread control and priority floor special registers of the core
`timescale 1ns/1ps
module stack_and_priority_mask_ctrl (
  input  wire logic                                MCLK,
  input  wire logic                                RST_N,
  input  wire spmask_pkg::sreg_req_t               SREG_REQ,
  input  wire spmask_pkg::exc_evt_t                EXC_EVT,
  input  wire logic [spmask_pkg::FLOOR_W-1:0]      EXC_LEVEL,
  output logic [31:0]                              SREG_RDATA,
  output logic                                     SREG_RVALID,
  output logic                                     USE_PSP,
  output logic                                     THREAD_UNPRIV,
  output logic [spmask_pkg::FLOOR_W-1:0]           PRIO_FLOOR,
  output logic                                     EXC_BLOCKED
);
  import spmask_pkg::*;

  ctl_state_t st_r;
  ctl_state_t st_nxt;
  logic       blk_nxt;
  logic       blk_r;
  logic       handler_after;

  // Compare result is registered so the blocking answer leaves from a flop like the rest
  prio_floor_cmp u_cmp (
    .floor   (st_r.floor),
    .level   (EXC_LEVEL),
    .blocked (blk_nxt)
  );

  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.rdata  = 32'h0000_0000;
    // Mode follows the request flag unless an event changes it this cycle
    handler_after = SREG_REQ.handler;
    if (SREG_REQ.rd && SREG_REQ.privileged) begin
      st_nxt.rvalid = 1'b1;
      case (SREG_REQ.sel)
        SREG_PRIO_FLOOR: st_nxt.rdata[FLOOR_LSB +: FLOOR_W] = st_r.floor;
        SREG_THREAD_CTL: begin
          st_nxt.rdata[ASEL_BIT]  = st_r.asel;
          st_nxt.rdata[TPRIV_BIT] = st_r.tpriv;
        end
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (SREG_REQ.wr && SREG_REQ.privileged) begin
      case (SREG_REQ.sel)
        SREG_PRIO_FLOOR: st_nxt.floor = SREG_REQ.wdata[FLOOR_LSB +: FLOOR_W];
        SREG_THREAD_CTL: begin
          st_nxt.tpriv = SREG_REQ.wdata[TPRIV_BIT];
          if (!SREG_REQ.handler)
            st_nxt.asel = SREG_REQ.wdata[ASEL_BIT];
        end
        default: st_nxt.floor = st_r.floor;
      endcase
    end
    // Exception sequencing outranks a same-cycle register write
    if (EXC_EVT.entry) begin
      st_nxt.asel   = 1'b0;
      handler_after = 1'b1;
    end else if (EXC_EVT.ret) begin
      handler_after = !EXC_EVT.code[ERC_THREAD_BIT];
      st_nxt.asel   = EXC_EVT.code[ERC_SPSEL_BIT];
    end
    st_nxt.use_psp = st_nxt.asel && !handler_after;
    st_nxt.unpriv  = st_nxt.tpriv && !handler_after;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st_r       <= '0;
      st_r.floor <= FLOOR_RST;
      st_r.asel  <= ASEL_RST;
      st_r.tpriv <= TPRIV_RST;
      blk_r      <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      blk_r <= blk_nxt;
    end
  end

  assign SREG_RDATA    = st_r.rdata;
  assign SREG_RVALID   = st_r.rvalid;
  assign USE_PSP       = st_r.use_psp;
  assign THREAD_UNPRIV = st_r.unpriv;
  assign PRIO_FLOOR    = st_r.floor;
  assign EXC_BLOCKED   = blk_r;

  property p_unpriv_write_ignored;
    @(posedge MCLK) disable iff (!RST_N)
    (SREG_REQ.wr && !SREG_REQ.privileged && !EXC_EVT.entry && !EXC_EVT.ret)
      |=> ($stable(st_r.asel) && $stable(st_r.tpriv) && $stable(st_r.floor));
  endproperty
  a_unpriv_write_ignored: assert property (p_unpriv_write_ignored)
    else $error("unprivileged write changed a register");

  property p_handler_no_psp;
    @(posedge MCLK) disable iff (!RST_N)
    EXC_EVT.entry |=> !USE_PSP;
  endproperty
  a_handler_no_psp: assert property (p_handler_no_psp)
    else $error("process stack in use after entry");

  property p_handler_asel_kept;
    @(posedge MCLK) disable iff (!RST_N)
    (SREG_REQ.wr && SREG_REQ.privileged && SREG_REQ.handler && !EXC_EVT.ret
      && SREG_REQ.sel == SREG_THREAD_CTL && !EXC_EVT.entry) |=> $stable(st_r.asel);
  endproperty
  a_handler_asel_kept: assert property (p_handler_asel_kept)
    else $error("handler write changed stack select");

  sequence s_return_to_psp;
    EXC_EVT.ret && EXC_EVT.code[ERC_THREAD_BIT] && EXC_EVT.code[ERC_SPSEL_BIT];
  endsequence
  property p_return_psp;
    @(posedge MCLK) disable iff (!RST_N)
    s_return_to_psp |=> USE_PSP ##0 st_r.asel;
  endproperty
  a_return_psp: assert property (p_return_psp)
    else $error("return code did not select process stack");

  property p_reset_msp;
    @(posedge MCLK) !RST_N |=> (!USE_PSP && !THREAD_UNPRIV && PRIO_FLOOR == 3'h0);
  endproperty
  a_reset_msp: assert property (p_reset_msp)
    else $error("reset state wrong");

  property p_thread_write_psp;
    @(posedge MCLK) disable iff (!RST_N)
    (SREG_REQ.wr && SREG_REQ.privileged && !SREG_REQ.handler && !EXC_EVT.entry
      && !EXC_EVT.ret && SREG_REQ.sel == SREG_THREAD_CTL && SREG_REQ.wdata[1])
      |=> USE_PSP;
  endproperty
  a_thread_write_psp: assert property (p_thread_write_psp)
    else $error("thread write did not select process stack");

  property p_ctl_readback;
    @(posedge MCLK) disable iff (!RST_N)
    (SREG_REQ.rd && SREG_REQ.privileged && SREG_REQ.sel == SREG_THREAD_CTL)
      |=> SREG_RVALID && SREG_RDATA == {30'h0, $past(st_r.asel), $past(st_r.tpriv)};
  endproperty
  a_ctl_readback: assert property (p_ctl_readback)
    else $error("thread control readback wrong");

  property p_tpriv_write;
    @(posedge MCLK) disable iff (!RST_N)
    (SREG_REQ.wr && SREG_REQ.privileged && SREG_REQ.sel == SREG_THREAD_CTL)
      |=> st_r.tpriv == $past(SREG_REQ.wdata[0]);
  endproperty
  a_tpriv_write: assert property (p_tpriv_write)
    else $error("privilege bit not written");

  property p_block;
    @(posedge MCLK) disable iff (!RST_N)
    1'b1 |=> EXC_BLOCKED == ($past(st_r.floor) != 3'h0 && $past(EXC_LEVEL) >= $past(st_r.floor));
  endproperty
  a_block: assert property (p_block)
    else $error("floor masking wrong");

  property p_floor_write;
    @(posedge MCLK) disable iff (!RST_N)
    (SREG_REQ.wr && SREG_REQ.privileged && SREG_REQ.sel == SREG_PRIO_FLOOR)
      |=> PRIO_FLOOR == $past(SREG_REQ.wdata[7:5]);
  endproperty
  a_floor_write: assert property (p_floor_write)
    else $error("floor not written");

  // Thread outputs mirror the control bits when no event and no Handler mode
  sequence s_quiet_thread;
    !EXC_EVT.entry && !EXC_EVT.ret && !SREG_REQ.handler;
  endsequence

  property p_thread_follows_bits;
    @(posedge MCLK) disable iff (!RST_N)
    s_quiet_thread |=> (USE_PSP == st_r.asel) && (THREAD_UNPRIV == st_r.tpriv);
  endproperty
  a_thread_follows_bits: assert property (p_thread_follows_bits)
    else $error("thread outputs do not follow control bits");

  property p_handler_msp_priv;
    @(posedge MCLK) disable iff (!RST_N)
    (EXC_EVT.entry || (SREG_REQ.handler && !EXC_EVT.ret))
      |=> !USE_PSP && !THREAD_UNPRIV;
  endproperty
  a_handler_msp_priv: assert property (p_handler_msp_priv)
    else $error("handler mode left the main stack or privilege");

  property p_read_needs_priv;
    @(posedge MCLK) disable iff (!RST_N)
    !(SREG_REQ.rd && SREG_REQ.privileged)
      |=> !SREG_RVALID && (SREG_RDATA == 32'h0000_0000);
  endproperty
  a_read_needs_priv: assert property (p_read_needs_priv)
    else $error("read answered without privilege");

  property p_entry_clears_asel;
    @(posedge MCLK) disable iff (!RST_N)
    EXC_EVT.entry |=> !st_r.asel;
  endproperty
  a_entry_clears_asel: assert property (p_entry_clears_asel)
    else $error("entry kept the stack select bit");

  property p_return_msp;
    @(posedge MCLK) disable iff (!RST_N)
    (EXC_EVT.ret && !EXC_EVT.entry && !EXC_EVT.code[ERC_SPSEL_BIT])
      |=> !st_r.asel && !USE_PSP;
  endproperty
  a_return_msp: assert property (p_return_msp)
    else $error("return code did not select main stack");

  property p_floor_readback;
    @(posedge MCLK) disable iff (!RST_N)
    (SREG_REQ.rd && SREG_REQ.privileged && SREG_REQ.sel == SREG_PRIO_FLOOR)
      |=> SREG_RVALID && (SREG_RDATA == (32'($past(st_r.floor)) << FLOOR_LSB));
  endproperty
  a_floor_readback: assert property (p_floor_readback)
    else $error("priority floor readback wrong");
endmodule

/* File: tb/stack_and_priority_mask_ctrl_tb.sv */
// Self-checking bench for the stack select and priority floor block
`timescale 1ns/1ps
module stack_and_priority_mask_ctrl_tb;
  import spmask_pkg::*;
  logic               mclk;
  logic               rst_n;
  sreg_req_t          req;
  exc_evt_t           evt;
  logic [FLOOR_W-1:0] level;
  logic [31:0]        rdata;
  logic               rvalid;
  logic               use_psp;
  logic               unpriv;
  logic [FLOOR_W-1:0] floor;
  logic               blocked;
  int                 fail_count;
  int                 samples_checked;
  int                 cycles;

  stack_and_priority_mask_ctrl dut (.MCLK(mclk), .RST_N(rst_n), .SREG_REQ(req),
    .EXC_EVT(evt), .EXC_LEVEL(level), .SREG_RDATA(rdata), .SREG_RVALID(rvalid),
    .USE_PSP(use_psp), .THREAD_UNPRIV(unpriv), .PRIO_FLOOR(floor), .EXC_BLOCKED(blocked));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task print_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      print_verdict();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One request cycle; outputs of the taking edge are settled on return
  task access(input logic w, input logic [1:0] s, input logic [31:0] d, input logic p,
              input logic h);
    @(posedge mclk);
    req.wr <= w;
    req.rd <= ~w;
    req.sel <= s;
    req.wdata <= d;
    req.privileged <= p;
    req.handler <= h;
    @(posedge mclk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    req.handler <= 1'b0;
    #1;
  endtask

  task rd_chk(input logic [1:0] s, input logic [31:0] exp);
    access(1'b0, s, 32'h0, 1'b1, 1'b0);
    check(rvalid, 1'b1, "read valid");
    check(rdata, exp, "read data");
  endtask

  task event_pulse(input logic e, input logic r, input logic [ERC_W-1:0] c);
    @(posedge mclk);
    evt <= '{e, r, c};
    @(posedge mclk);
    evt <= '0;
    #1;
  endtask

  task t_reset();
    check(use_psp, 1'b0, "reset stack");
    check(unpriv, 1'b0, "reset privilege");
    check(floor, 3'h0, "reset floor");
    rd_chk(SREG_THREAD_CTL, 32'h0);
    rd_chk(SREG_PRIO_FLOOR, 32'h0);
    rd_chk(2'h3, 32'h0);
    $display("reset test done");
  endtask

  task t_write();
    access(1'b1, SREG_THREAD_CTL, 32'h2, 1'b1, 1'b0);
    check(use_psp, 1'b1, "select to process stack");
    rd_chk(SREG_THREAD_CTL, 32'h2);
    access(1'b1, SREG_THREAD_CTL, 32'h1, 1'b1, 1'b0);
    check(use_psp, 1'b0, "select to main stack");
    check(unpriv, 1'b1, "thread unprivileged");
    access(1'b1, SREG_THREAD_CTL, 32'h0, 1'b1, 1'b0);
    check(unpriv, 1'b0, "thread privileged");
    $display("write test done");
  endtask

  task t_refused();
    access(1'b1, SREG_THREAD_CTL, 32'h2, 1'b0, 1'b0);
    check(use_psp, 1'b0, "unprivileged write");
    access(1'b0, SREG_THREAD_CTL, 32'h0, 1'b0, 1'b0);
    check(rvalid, 1'b0, "unprivileged read");
    access(1'b1, SREG_THREAD_CTL, 32'h3, 1'b1, 1'b1);
    rd_chk(SREG_THREAD_CTL, 32'h1);
    access(1'b1, SREG_THREAD_CTL, 32'h0, 1'b1, 1'b0);
    $display("refusal test done");
  endtask

  task t_exception();
    access(1'b1, SREG_THREAD_CTL, 32'h2, 1'b1, 1'b0);
    event_pulse(1'b1, 1'b0, 4'h0);
    check(use_psp, 1'b0, "entry uses main stack");
    event_pulse(1'b0, 1'b1, 4'hC);
    check(use_psp, 1'b1, "return to process stack");
    rd_chk(SREG_THREAD_CTL, 32'h2);
    event_pulse(1'b0, 1'b1, 4'h8);
    check(use_psp, 1'b0, "return to main stack");
    $display("exception test done");
  endtask

  task t_floor();
    for (int f = 0; f < 8; f++) begin
      access(1'b1, SREG_PRIO_FLOOR, 32'hFFFFFF1F | (f << 5), 1'b1, 1'b0);
      check(floor, f[2:0], "floor field");
      rd_chk(SREG_PRIO_FLOOR, f << 5);
      for (int l = 0; l < 8; l++) begin
        @(posedge mclk);
        level <= l[2:0];
        @(posedge mclk);
        #1;
        check(blocked, (f != 0 && l >= f), "blocking");
      end
    end
    $display("floor test done");
  endtask

  task t_reset_again();
    access(1'b1, SREG_THREAD_CTL, 32'h3, 1'b1, 1'b0);
    access(1'b1, SREG_PRIO_FLOOR, 32'hE0, 1'b1, 1'b0);
    check(use_psp, 1'b1, "process stack before reset");
    check(unpriv, 1'b1, "unprivileged before reset");
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    check(use_psp, 1'b0, "stack after reset");
    check(unpriv, 1'b0, "privilege after reset");
    check(floor, 3'h0, "floor after reset");
    rd_chk(SREG_THREAD_CTL, 32'h0);
    $display("second reset test done");
  endtask

  initial begin
    rst_n <= 1'b0;
    req <= '0;
    evt <= '0;
    level <= '0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    t_reset();
    t_write();
    t_refused();
    t_exception();
    t_floor();
    t_reset_again();
    print_verdict();
  end
endmodule
